// File: rtl/sdf_filter.sv
// sinc3 decimation filter with apb register access
//
// Implementation choices: the address map and register access over APB.
`default_nettype none

// Summary of operation
// - sinc cubed low-pass on modulator bitstream
// - length n equals decimation, unity dc gain
// - modulator samples taken at clock over 128
// - output word rate equals first notch
// - notches at multiples of first notch, except multiples of sample rate
// - notch select moves notches, keeps shape
// - cutoff scales with first notch frequency
// - words invalid until filter has settled
// - synchronised start settles in three words
// - headroom above full scale, no saturation
// - no rejection at multiples of sample rate
module sdf_filter
   import sdf_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        mod_bit_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [31:0]      prdata_out,
   output logic             word_valid_out
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [3:0] ratio_log2(input logic [2:0] sel);
      ratio_log2 = 4'(K_MIN) + {1'b0, sel};
   endfunction

   // divide by n**3 as a shift, n being a power of two
   function automatic logic [WORD_W-1:0] scale_word(
      input logic [ACC_W-1:0] v,
      input logic [2:0]       sel
   );
      logic signed [ACC_W+FRAC_W-1:0] wide;
      logic [5:0]                     sh;
      wide = $signed({v, {FRAC_W{1'b0}}});
      sh   = 6'(3 * ratio_log2(sel));
      wide = wide >>> sh;
      scale_word = wide[WORD_W-1:0];
   endfunction

   sdf_state_t q;
   sdf_state_t d;

   logic        acc_setup;
   logic        acc_done;
   logic [10:0] dec_last;
   logic        restart;
   logic        mod_tick;
   logic        word_tick;
   logic [ACC_W-1:0] x;
   logic [ACC_W-1:0] d1;
   logic [ACC_W-1:0] d2;
   logic [ACC_W-1:0] d3;

   always_comb
   begin
      d = q;

      // ----------------------------------------
      // modulator bit synchroniser
      // ----------------------------------------
      d.sync1 = mod_bit_in;
      d.sync2 = q.sync1;

      // ----------------------------------------
      // apb slave, zero wait states
      // ----------------------------------------
      acc_setup = psel_in && !penable_in;
      acc_done  = psel_in && penable_in && q.pready;
      d.pready  = acc_setup;
      d.wpulse  = 1'b0;
      restart   = q.hold;
      if (acc_setup)
      begin
         d.pslverr = 1'b0;
         d.prdata  = 32'h0000_0000;
         if (paddr_in == ADDR_CTRL)
         begin
            d.prdata[CTRL_SEL_LSB +: 3] = q.sel;
            d.prdata[CTRL_HOLD_BIT]     = q.hold;
         end
         else if (paddr_in == ADDR_STATUS)
         begin
            d.prdata[STAT_RDY_BIT]      = q.rdy;
            d.prdata[STAT_SET_LSB +: 3] = q.settle;
         end
         else if (paddr_in == ADDR_DATA)
         begin
            d.prdata = {{(32-WORD_W){q.word[WORD_W-1]}}, q.word};
         end
         else
         begin
            d.pslverr = 1'b1;
         end
      end
      if (acc_done)
      begin
         if (!pwrite_in && paddr_in == ADDR_DATA)
         begin
            d.rdy = 1'b0;
         end
         if (pwrite_in && paddr_in == ADDR_CTRL)
         begin
            d.sel  = pwdata_in[CTRL_SEL_LSB +: 3];
            d.hold = pwdata_in[CTRL_HOLD_BIT];
            if (d.sel != q.sel)
            begin
               restart = 1'b1;
            end
         end
      end

      // ----------------------------------------
      // modulator rate and decimation timing
      // ----------------------------------------
      // one sample per 128 clocks
      mod_tick  = (q.div == MOD_DIV_LAST);
      d.div     = mod_tick ? 7'h00 : q.div + 7'h01;
      dec_last  = 11'((12'h001 << ratio_log2(q.sel)) - 12'h001);
      word_tick = mod_tick && (q.dec == dec_last);

      // ----------------------------------------
      // integrators at modulator rate
      // ----------------------------------------
      // bit maps to plus or minus one, wide sums
      x  = q.sync2 ? ACC_W'(1) : {ACC_W{1'b1}};
      d1 = q.int3 - q.cd1;
      d2 = d1 - q.cd2;
      d3 = d2 - q.cd3;
      if (mod_tick)
      begin
         d.int1 = q.int1 + x;
         d.int2 = q.int2 + q.int1;
         d.int3 = q.int3 + q.int2;
         d.dec  = word_tick ? 11'h000 : q.dec + 11'h001;
      end

      // ----------------------------------------
      // differencers at output rate
      // ----------------------------------------
      // comb of three gives sinc cubed
      // zeros of comb at multiples of rate
      // cutoff tied to n, so to the notch
      // images at sample rate multiples pass
      // one word per n samples, at first notch
      if (word_tick)
      begin
         d.cd1 = q.int3;
         d.cd2 = d1;
         d.cd3 = d2;
         // divide by n cubed for unity gain
         d.word = scale_word(d3, q.sel);
         if (q.settle != SETTLE_SYNC)
         begin
            d.settle = q.settle + 3'h1;
         end
         if (d.settle == SETTLE_SYNC)
         begin
            d.rdy    = 1'b1;
            d.wpulse = 1'b1;
         end
      end

      // ----------------------------------------
      // hold and restart: zero state, aligned start
      // ----------------------------------------
      // restart clears history, three words
      if (restart)
      begin
         d.div    = 7'h00;
         d.dec    = 11'h000;
         d.int1   = '0;
         d.int2   = '0;
         d.int3   = '0;
         d.cd1    = '0;
         d.cd2    = '0;
         d.cd3    = '0;
         d.settle = 3'h0;
         d.wpulse = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         q      <= '0;
         q.sel  <= RST_NOTCH_SEL;
         q.hold <= RST_HOLD;
      end
      else
      begin
         q <= d;
      end
   end

   assign pready_out     = q.pready;
   assign pslverr_out    = q.pslverr;
   assign prdata_out     = q.prdata;
   assign word_valid_out = q.wpulse;

endmodule // sdf_filter
`default_nettype wire

// File: rtl/sdf_pkg.sv
// constants and state type for the sinc3 decimation filter
`default_nettype none
package sdf_pkg;
   // ----------------------------------------
   // clocking and modulator rate
   // ----------------------------------------
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned MOD_DIV      = 128;
   localparam int unsigned MOD_HZ       = CLK_HZ / MOD_DIV;
   localparam logic [6:0]  MOD_DIV_LAST = 7'(MOD_DIV - 1);

   // ----------------------------------------
   // decimation ratio: n = 2**(K_MIN + select)
   // ----------------------------------------
   localparam int unsigned K_MIN  = 4;
   localparam int unsigned K_MAX  = 11;
   localparam int unsigned ACC_W  = 3 * K_MAX + 3;
   localparam int unsigned FRAC_W = 20;
   localparam int unsigned WORD_W = 24;
   localparam logic [2:0]  SETTLE_SYNC = 3'h3;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_DATA   = 12'h008;
   localparam int unsigned CTRL_SEL_LSB  = 0;
   localparam int unsigned CTRL_HOLD_BIT = 3;
   localparam int unsigned STAT_RDY_BIT  = 0;
   localparam int unsigned STAT_SET_LSB  = 1;
   localparam logic [2:0]  RST_NOTCH_SEL = 3'h0;
   localparam logic        RST_HOLD      = 1'b0;

   typedef struct packed {
      logic               sync1;
      logic               sync2;
      logic [6:0]         div;
      logic [10:0]        dec;
      logic [ACC_W-1:0]   int1;
      logic [ACC_W-1:0]   int2;
      logic [ACC_W-1:0]   int3;
      logic [ACC_W-1:0]   cd1;
      logic [ACC_W-1:0]   cd2;
      logic [ACC_W-1:0]   cd3;
      logic [WORD_W-1:0]  word;
      logic [2:0]         settle;
      logic               rdy;
      logic               wpulse;
      logic [2:0]         sel;
      logic               hold;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
   } sdf_state_t;
endpackage : sdf_pkg
`default_nettype wire

// File: verification/sdf_bitsrc.sv
// modulator bitstream source model
`default_nettype none
module sdf_bitsrc (
   input  wire logic [1:0] mode_in,
   input  wire logic       clk_in,
   output var  logic       bit_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q = 8'h00;
   initial bit_out = 1'b0;
   always @(posedge clk_in)
   begin
      cnt_q <= cnt_q + 8'h01;
      // mode 2 alternates, a tone at half the sample rate
      if (cnt_q[6:0] == 7'h7f)
         bit_out <= (mode_in == 2'h2) ? ~cnt_q[7] : mode_in[0];
   end
endmodule // sdf_bitsrc
`default_nettype wire

// File: verification/sdf_filter_props.sv
// bus and word stream assertions for the filter
`default_nettype none
module sdf_filter_props (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic [11:0] paddr_in,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic [31:0] prdata_out,
   input wire logic        word_valid_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_gap;
      !word_valid_out [*8];
   endsequence
   logic rd_q;
   assign rd_q = pready_out;
   a_zero_wait: assert property (s_setup |=> pready_out)
      else $error("no answer after setup");
   a_ready_cause: assert property (pready_out |-> $past(psel_in && !penable_in))
      else $error("answer without setup");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("answer longer than one cycle");
   a_unmapped_err: assert property (rd_q && paddr_in > 12'h008 |->
      pslverr_out && prdata_out == 32'h0)
      else $error("unmapped access not refused");
   a_ctrl_read: assert property (rd_q && paddr_in == 12'h000 |->
      !pslverr_out && prdata_out[31:4] == 28'h0)
      else $error("control read wrong");
   a_stat_read: assert property (rd_q && paddr_in == 12'h004 |->
      !pslverr_out && prdata_out[31:4] == 28'h0)
      else $error("status read wrong");
   a_data_sign: assert property (rd_q && paddr_in == 12'h008 |->
      prdata_out[31:24] == {8{prdata_out[23]}})
      else $error("data word not sign extended");
   a_word_gap: assert property (word_valid_out |=> s_gap)
      else $error("word pulses too close");
endmodule // sdf_filter_props
bind sdf_filter sdf_filter_props i_props (.clk_in, .resetn_in, .psel_in, .penable_in,
   .paddr_in, .pready_out, .pslverr_out, .prdata_out, .word_valid_out);
`default_nettype wire

// File: verification/sdf_filter_tb_top.sv
// self-checking bench for the sinc3 decimation filter
`default_nettype none
module sdf_filter_tb_top;
   import sdf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, mbit, pready, wv, pslverr;
   logic        err_s;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] mode = 2'h1;
   logic [31:0] exp_w [3] = '{32'h00100000, 32'hfff00000, 32'h00000000};
   logic [1:0] mode_t [3] = '{2'h1, 2'h0, 2'h2};
   int errors = 0, comparisons = 0, c, n;
   always #12.5 clk = ~clk;
   sdf_bitsrc i_src (.clk_in(clk), .mode_in(mode), .bit_out(mbit));
   sdf_filter i_dut (.clk_in(clk), .resetn_in(resetn), .mod_bit_in(mbit), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .word_valid_out(wv));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ready and data read right at the rising edge, before that edge updates them
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++t < 16);
      rd = prdata;
      err_s = pslverr;
      if (pready !== 1'b1)
         errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_word(input int lim);
      c = 0;
      do @(negedge clk); while (wv !== 1'b1 && ++c < lim);
   endtask
   task automatic conclude();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (90000) @(posedge clk);
      errors++;
      conclude();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err_s), 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err_s), 32'h1);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         n = 16 << i;
         // software chooses the rate; mains rates not reachable here
         apb(1'b1, 12'h000, 32'h8 | 32'(i));
         mode <= mode_t[i];
         wait_word(3000);
         chk(32'(c), 32'd3000);
         apb(1'b1, 12'h000, 32'(i));
         wait_word(70000);
         chk(32'(c > 3 * n * 128 - 130 && c < 3 * n * 128 + 130), 32'h1);
         wait_word(70000);
         chk(32'(c), 32'(n * 128 - 1));
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, 32'h7);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd, exp_w[i]);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, 32'h6);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, 32'(i));
         $display("test %0d done", i);
      end
      conclude();
   end
endmodule // sdf_filter_tb_top
`default_nettype wire
